// ### rtl/ccse_alu.sv
// Purpose: Decode and arithmetic for complement, compare-skip and decimal adjust
// Assumes: Operand already read from data memory
// Notes:   Combinational; the core samples it at the end of Q3
`include "ccse_regs.svh"

module ccse_alu (
  ccse_alu_if.alu bus   // Operands in, results out
);

  function automatic logic over_nine(input logic [3:0] nib);
    over_nine = (nib > `CCSE_BCD_LIMIT);
  endfunction

  wire        is_comp = (bus.instr[15:9] == `CCSE_OP_COMP_HI7);
  wire        is_dadj = (bus.instr[15:9] == `CCSE_OP_DADJ_HI7);
  wire        is_cpeq = (bus.instr[15:8] == `CCSE_OP_CPEQ_HI8);
  wire        is_cpgt = (bus.instr[15:8] == `CCSE_OP_CPGT_HI8);
  wire        is_cplt = (bus.instr[15:8] == `CCSE_OP_CPLT_HI8);
  wire        dest_f  = bus.instr[`CCSE_OP_DEST_BIT];

  // Unsigned subtract f - W; the borrow out decides the ordering
  wire [8:0]  diff    = {1'b0, bus.operand} - {1'b0, bus.working_register};
  wire        eq      = (diff == 9'h000);
  wire        lt      = diff[8];
  wire        gt      = !lt && !eq;

  wire        adj_lo  = over_nine(bus.working_register[3:0]) || bus.digit_carry;
  wire [8:0]  part    = {1'b0, bus.working_register} + (adj_lo ? `CCSE_BCD_ADJ_LO : 9'h000);
  wire        adj_hi  = over_nine(part[7:4]) || part[8] || bus.c;
  wire [8:0]  bcd     = part + (adj_hi ? `CCSE_BCD_ADJ_HI : 9'h000);

  assign bus.op     = is_comp ? ccse_pkg::OP_COMP :
                      is_dadj ? ccse_pkg::OP_DADJ :
                      is_cpeq ? ccse_pkg::OP_CPEQ :
                      is_cpgt ? ccse_pkg::OP_CPGT :
                      is_cplt ? ccse_pkg::OP_CPLT : ccse_pkg::OP_OTHER;
  assign bus.result = is_comp ? ~bus.operand : (is_dadj ? bcd[7:0] : 8'h00);
  assign bus.skip   = (is_cpeq && eq) || (is_cpgt && gt) || (is_cplt && lt);
  // Destination: complement by d, adjust always to f and to W only when s is 0
  assign bus.wr_f   = (is_comp && dest_f) || is_dadj;
  assign bus.wr_w   = (is_comp && !dest_f) || (is_dadj && !dest_f);
  assign bus.upd_z  = is_comp;
  assign bus.upd_c  = is_dadj;
  assign bus.carry  = adj_hi;

endmodule

// ### rtl/ccse_alu_if.sv
// Purpose: Carries operands and results between core sequencer and ALU
// Assumes: Purely combinational path inside one clock domain
// Notes:   None
interface ccse_alu_if;
  logic [15:0]         instr;
  logic [7:0]          operand;
  logic [7:0]          working_register;
  logic                digit_carry;
  logic                c;
  ccse_pkg::op_type    op;
  logic [7:0]          result;
  logic                skip;
  logic                wr_f;
  logic                wr_w;
  logic                upd_z;
  logic                upd_c;
  logic                carry;

  modport core (output instr, operand, working_register, digit_carry, c,
                input  op, result, skip, wr_f, wr_w, upd_z, upd_c, carry);
  modport alu  (input  instr, operand, working_register, digit_carry, c,
                output op, result, skip, wr_f, wr_w, upd_z, upd_c, carry);
endinterface

// ### rtl/ccse_pkg.sv
// Purpose: Shared types of the execution slice
// Assumes: Constants live in ccse_regs.svh
// Notes:   Binary codes written out for waveform reading
package ccse_pkg;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_type;

  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_COMP  = 3'b001,
    OP_CPEQ  = 3'b010,
    OP_CPGT  = 3'b011,
    OP_CPLT  = 3'b100,
    OP_DADJ  = 3'b101
  } op_type;

endpackage

// ### rtl/ccse_regs.svh
// Purpose: Constants for the complement, compare-skip and decimal adjust execution slice
// Assumes: 16-bit instruction words, 8-bit data memory, four clocks per instruction cycle
// Notes:   Register bus offsets are word indices on a 2-bit address
//
// Summary of operation
// - Complement reads location, produces bitwise inverse
// - Dest bit 0 writes working register (adjust also writes location), 1 location
// - Equal compare decoded from high byte 31
// - Equal compare skips when location equals working register
// - Greater compare, high byte 32, skips when larger
// - Less compare, high byte 30, skips when smaller
// - Compares use unsigned subtract, no flags, no write
// - Taken skip discards fetched word, forces NOP
// - Adjust adds six to low nibble above nine or on digit carry
// - Decimal adjust yields packed BCD from BCD sum
`ifndef CCSE_REGS_SVH
`define CCSE_REGS_SVH

`define CCSE_OP_COMP_HI7   7'h09
`define CCSE_OP_DADJ_HI7   7'h17
`define CCSE_OP_CPEQ_HI8   8'h31
`define CCSE_OP_CPGT_HI8   8'h32
`define CCSE_OP_CPLT_HI8   8'h30
`define CCSE_OP_DEST_BIT   8
`define CCSE_NOP_WORD      16'h0000

`define CCSE_BCD_LIMIT     4'h9
`define CCSE_BCD_ADJ_LO    9'h006
`define CCSE_BCD_ADJ_HI    9'h060

`define CCSE_ADDR_WORK     2'h0
`define CCSE_ADDR_STATUS   2'h1
`define CCSE_ADDR_STATE    2'h2

`define CCSE_ST_C_BIT      0
`define CCSE_ST_DIGIT_BIT  1
`define CCSE_ST_Z_BIT      2

`define CCSE_WORK_RESET    8'h00
`define CCSE_STATUS_RESET  3'h0
`define CCSE_CYCLE_CLOCKS  4

`endif

// ### rtl/complement_compare_skip_exec.sv
// Purpose: Four-phase execution of complement, compare-skip and decimal adjust
// Assumes: Data memory answers a read within the clock after the address changes
// Notes:   Other opcodes pass through as one-cycle NOPs here
`include "ccse_regs.svh"

module complement_compare_skip_exec (
  input  wire logic        clk_sys_in,        // 50 MHz core clock
  input  wire logic        rst_in,            // Synchronous reset, active high
  input  wire logic [15:0] instr_in,          // Fetched word, sampled at end of Q1
  output logic             instr_discard_out, // Pulse: fetched word dropped
  output logic [7:0]       dmem_addr_out,     // Data memory address
  input  wire logic [7:0]  dmem_rd_data_in,   // Data memory read data
  output logic [7:0]       dmem_wr_data_out,  // Data memory write data
  output logic             dmem_we_out,       // Pulse: data memory write
  output logic [1:0]       phase_out,         // Q phase, one clock behind the internal phase
  input  wire logic [1:0]  reg_addr_in,       // Register bus address
  input  wire logic [7:0]  reg_wr_data_in,    // Register bus write data
  input  wire logic        reg_wr_in,         // Register bus write strobe
  input  wire logic        reg_rd_in,         // Register bus read strobe
  output logic [7:0]       reg_rd_data_out    // Read data, one cycle after strobe
);

  ccse_pkg::phase_type phase_r;
  logic [15:0]         instr_r;
  logic [7:0]          operand_r;
  logic [7:0]          working_register_r;
  logic [2:0]          status_r;
  logic [7:0]          res_r;
  ccse_pkg::op_type    op_r;
  logic                skip_r;
  logic                wr_f_r;
  logic                wr_w_r;
  logic                upd_z_r;
  logic                upd_c_r;
  logic                carry_r;
  logic                skip_pending_r;

  ccse_alu_if alu_bus ();

  ccse_alu u_alu (
    .bus (alu_bus)
  );

  assign alu_bus.instr   = instr_r;
  assign alu_bus.operand = operand_r;
  assign alu_bus.working_register    = working_register_r;
  assign alu_bus.digit_carry = status_r[`CCSE_ST_DIGIT_BIT];
  assign alu_bus.c       = status_r[`CCSE_ST_C_BIT];

  wire q1     = (phase_r == ccse_pkg::PH_Q1);
  wire q2     = (phase_r == ccse_pkg::PH_Q2);
  wire q3     = (phase_r == ccse_pkg::PH_Q3);
  wire q4     = (phase_r == ccse_pkg::PH_Q4);
  // A taken skip turns the word fetched meanwhile into a NOP
  wire forced = q1 && skip_pending_r;
  wire [15:0] instr_nxt = forced ? `CCSE_NOP_WORD : instr_in;

  wire sw_working_register   = reg_wr_in && (reg_addr_in == `CCSE_ADDR_WORK);
  wire sw_status = reg_wr_in && (reg_addr_in == `CCSE_ADDR_STATUS);
  wire core_w    = q4 && wr_w_r;
  // Core commit wins over a software write landing in the same Q4
  wire [7:0] working_register_nxt = core_w ? res_r : (sw_working_register ? reg_wr_data_in : working_register_r);

  wire [2:0] flags_core;
  assign flags_core[`CCSE_ST_Z_BIT]  = upd_z_r ? (res_r == 8'h00)
                                               : status_r[`CCSE_ST_Z_BIT];
  assign flags_core[`CCSE_ST_DIGIT_BIT] = status_r[`CCSE_ST_DIGIT_BIT];
  assign flags_core[`CCSE_ST_C_BIT]  = upd_c_r ? carry_r : status_r[`CCSE_ST_C_BIT];
  wire [2:0] status_nxt = q4 ? flags_core
                             : (sw_status ? reg_wr_data_in[2:0] : status_r);

  wire [7:0] rd_mux = (reg_addr_in == `CCSE_ADDR_WORK)   ? working_register_r :
                      (reg_addr_in == `CCSE_ADDR_STATUS) ? {5'h00, status_r} :
                      (reg_addr_in == `CCSE_ADDR_STATE)  ?
                        {5'h00, skip_pending_r, phase_r} : 8'h00;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      phase_r <= ccse_pkg::PH_Q1;
    end else begin
      case (phase_r)
        ccse_pkg::PH_Q1: phase_r <= ccse_pkg::PH_Q2;
        ccse_pkg::PH_Q2: phase_r <= ccse_pkg::PH_Q3;
        ccse_pkg::PH_Q3: phase_r <= ccse_pkg::PH_Q4;
        ccse_pkg::PH_Q4: phase_r <= ccse_pkg::PH_Q1;
        default:         phase_r <= ccse_pkg::PH_Q1;
      endcase
    end
  end

  // Decode and read: latch word and address in Q1, operand in Q2
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      instr_r           <= `CCSE_NOP_WORD;
      dmem_addr_out     <= 8'h00;
      operand_r         <= 8'h00;
      instr_discard_out <= 1'b0;
    end else begin
      instr_discard_out <= forced;
      if (q1) begin
        instr_r       <= instr_nxt;
        dmem_addr_out <= instr_nxt[7:0];
      end
      if (q2) begin
        operand_r <= dmem_rd_data_in;
      end
    end
  end

  // Execute in Q3
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      res_r   <= 8'h00;
      op_r    <= ccse_pkg::OP_OTHER;
      skip_r  <= 1'b0;
      wr_f_r  <= 1'b0;
      wr_w_r  <= 1'b0;
      upd_z_r <= 1'b0;
      upd_c_r <= 1'b0;
      carry_r <= 1'b0;
    end else if (q3) begin
      res_r   <= alu_bus.result;
      op_r    <= alu_bus.op;
      skip_r  <= alu_bus.skip;
      wr_f_r  <= alu_bus.wr_f;
      wr_w_r  <= alu_bus.wr_w;
      upd_z_r <= alu_bus.upd_z;
      upd_c_r <= alu_bus.upd_c;
      carry_r <= alu_bus.carry;
    end
  end

  // Commit in Q4; write strobe lands in the following Q1
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      working_register_r           <= `CCSE_WORK_RESET;
      status_r         <= `CCSE_STATUS_RESET;
      dmem_we_out      <= 1'b0;
      dmem_wr_data_out <= 8'h00;
      skip_pending_r   <= 1'b0;
    end else begin
      working_register_r      <= working_register_nxt;
      status_r    <= status_nxt;
      dmem_we_out <= q4 && wr_f_r;
      if (q4) begin
        dmem_wr_data_out <= res_r;
        skip_pending_r   <= skip_r;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rd_data_out <= 8'h00;
      phase_out       <= 2'b00;
    end else begin
      reg_rd_data_out <= reg_rd_in ? rd_mux : 8'h00;
      phase_out       <= phase_r;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_q4_of(ccse_pkg::op_type o);
    q4 && op_r == o;
  endsequence

  // Discard shows in Q2, so the forced NOP commits two cycles later
  sequence s_forced_nop;
    ##1 instr_discard_out ##2 q4 && !wr_f_r && !wr_w_r && !skip_r;
  endsequence

  property p_cpl_invert;
    q3 && alu_bus.op == ccse_pkg::OP_COMP |=> res_r == ~$past(operand_r);
  endproperty
  a_cpl_invert: assert property (p_cpl_invert) else $error("complement result wrong");

  property p_cpl_to_w;
    s_q4_of(ccse_pkg::OP_COMP) ##0 !instr_r[`CCSE_OP_DEST_BIT]
      |=> working_register_r == $past(res_r) && !dmem_we_out;
  endproperty
  a_cpl_to_w: assert property (p_cpl_to_w) else $error("complement d=0 misrouted");

  property p_cpl_to_f;
    s_q4_of(ccse_pkg::OP_COMP) ##0 instr_r[`CCSE_OP_DEST_BIT]
      |=> dmem_we_out && dmem_wr_data_out == $past(res_r) && dmem_addr_out == $past(instr_r[7:0]);
  endproperty
  a_cpl_to_f: assert property (p_cpl_to_f) else $error("complement d=1 misrouted");

  property p_cpl_flags;
    s_q4_of(ccse_pkg::OP_COMP)
      |=> status_r[`CCSE_ST_Z_BIT] == ($past(res_r) == 8'h00)
          && status_r[1:0] == $past(status_r[1:0]);
  endproperty
  a_cpl_flags: assert property (p_cpl_flags) else $error("complement flags wrong");

  property p_eq_skip;
    q3 && instr_r[15:8] == `CCSE_OP_CPEQ_HI8 |=>
      skip_r == ($past(operand_r) == $past(working_register_r)) ##1 skip_pending_r == skip_r;
  endproperty
  a_eq_skip: assert property (p_eq_skip) else $error("equal skip wrong");

  property p_gt_skip;
    q3 && instr_r[15:8] == `CCSE_OP_CPGT_HI8 |=> skip_r == ($past(operand_r) > $past(working_register_r));
  endproperty
  a_gt_skip: assert property (p_gt_skip) else $error("greater skip wrong");

  property p_lt_skip;
    q3 && instr_r[15:8] == `CCSE_OP_CPLT_HI8 |=> skip_r == ($past(operand_r) < $past(working_register_r));
  endproperty
  a_lt_skip: assert property (p_lt_skip) else $error("less skip wrong");

  property p_cmp_quiet;
    q4 && (op_r == ccse_pkg::OP_CPEQ || op_r == ccse_pkg::OP_CPGT || op_r == ccse_pkg::OP_CPLT)
      |=> !dmem_we_out && ($stable(working_register_r) || $past(sw_working_register)) && $stable(status_r);
  endproperty
  a_cmp_quiet: assert property (p_cmp_quiet) else $error("compare changed state");

  property p_skip_nop;
    q4 && skip_r |=> s_forced_nop;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("forced NOP missing");

  property p_dadj_lo;
    q3 && alu_bus.op == ccse_pkg::OP_DADJ && status_r[`CCSE_ST_DIGIT_BIT]
      && working_register_r[3:0] <= 4'h3 |=> res_r[3:0] == $past(working_register_r[3:0]) + 4'h6;
  endproperty
  a_dadj_lo: assert property (p_dadj_lo) else $error("adjust low nibble wrong");

  property p_dadj_bcd;
    q3 && alu_bus.op == ccse_pkg::OP_DADJ |=> res_r[3:0] <= 4'h9 && res_r[7:4] <= 4'h9;
  endproperty
  a_dadj_bcd: assert property (p_dadj_bcd) else $error("adjust not BCD");

endmodule

// ### testbench/ccse_dmem_model.sv
// Purpose: Data memory and fetch-side observer facing the execution slice
// Assumes: Reads answer at once from the current address
// Notes:   Counts discarded fetch words so skips can be checked
module ccse_dmem_model (
  input  wire logic       clk_sys_in,   // Core clock
  input  wire logic [7:0] addr_in,      // Data memory address
  input  wire logic [7:0] wr_data_in,   // Write data
  input  wire logic       we_in,        // Write pulse
  input  wire logic       discard_in,   // Fetched word dropped
  output logic      [7:0] rd_data_out   // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  int         discards;

  assign rd_data_out = mem[addr_in];

  initial begin
    discards = 0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end

  always @(posedge clk_sys_in) begin
    if (we_in === 1'b1) begin
      mem[addr_in] <= wr_data_in;
    end
    if (discard_in === 1'b1) begin
      discards <= discards + 1;
    end
  end

  // Only called while no instruction writes memory
  task automatic poke(input logic [7:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule

// ### testbench/complement_compare_skip_exec_bench.sv
// Purpose: Self-checking bench for complement, compare-skip and decimal adjust
// Assumes: Phase output lags the internal phase by one clock
// Notes:   Register writes are placed in Q1 so the core never overrides them
module complement_compare_skip_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in;
  logic        rst_in;
  logic [15:0] instr_in;
  logic        instr_discard_out;
  logic [7:0]  dmem_addr_out;
  logic [7:0]  dmem_rd_data_in;
  logic [7:0]  dmem_wr_data_out;
  logic        dmem_we_out;
  logic [1:0]  phase_out;
  logic [1:0]  reg_addr_in;
  logic [7:0]  reg_wr_data_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [7:0]  reg_rd_data_out;
  int          mismatches;
  int          checked;
  int          cycles;
  int          d0;
  logic [7:0]  rd;
  logic [7:0]  fv;
  logic        skip;

  complement_compare_skip_exec complement_compare_skip_exec_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .instr_in(instr_in),
    .instr_discard_out(instr_discard_out), .dmem_addr_out(dmem_addr_out),
    .dmem_rd_data_in(dmem_rd_data_in), .dmem_wr_data_out(dmem_wr_data_out),
    .dmem_we_out(dmem_we_out), .phase_out(phase_out), .reg_addr_in(reg_addr_in),
    .reg_wr_data_in(reg_wr_data_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rd_data_out(reg_rd_data_out));

  ccse_dmem_model ccse_dmem_model_i (
    .clk_sys_in(clk_sys_in), .addr_in(dmem_addr_out), .wr_data_in(dmem_wr_data_out),
    .we_in(dmem_we_out), .discard_in(instr_discard_out), .rd_data_out(dmem_rd_data_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      finish_test;
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Returns at the edge that opens a Q1 cycle
  task automatic sync_q1;
    do @(posedge clk_sys_in); while (phase_out !== 2'h2);
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    sync_q1;
    reg_addr_in    <= a;
    reg_wr_data_in <= d;
    reg_wr_in      <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in      <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    @(posedge clk_sys_in);
    d = reg_rd_data_out;
  endtask

  // Two back-to-back fetch slots, then NOPs; both words' writes have landed on return
  task automatic run(input logic [15:0] w1, input logic [15:0] w2);
    sync_q1;
    instr_in <= w1;
    repeat (4) @(posedge clk_sys_in);
    instr_in <= w2;
    repeat (4) @(posedge clk_sys_in);
    instr_in <= 16'h0000;
    repeat (2) @(posedge clk_sys_in);
  endtask

  initial begin
    mismatches = 0;
    checked = 0;
    cycles = 0;
    rst_in = 1'b1;
    instr_in = 16'h0000;
    reg_addr_in = 2'h0;
    reg_wr_data_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;

    reg_read(2'h3, rd); chk("unmapped", 8'h00, rd);
    reg_write(2'h3, 8'hff);
    reg_read(2'h3, rd); chk("unmapped", 8'h00, rd);
    reg_write(2'h0, 8'h55);
    reg_read(2'h0, rd); chk("w", 8'h55, rd);
    sync_q1;
    reg_read(2'h2, rd); chk("state", 8'h01, rd);
    $display("test registers done");

    ccse_dmem_model_i.poke(8'h10, 8'h13);
    reg_write(2'h1, 8'h01);
    run(16'h1310, 16'h0000);
    chk("mem10", 8'hec, ccse_dmem_model_i.mem[8'h10]);
    reg_read(2'h0, rd); chk("w", 8'h55, rd);
    reg_read(2'h1, rd); chk("status", 8'h01, rd);
    ccse_dmem_model_i.poke(8'h11, 8'hff);
    run(16'h1211, 16'h0000);
    reg_read(2'h0, rd); chk("w", 8'h00, rd);
    chk("mem11", 8'hff, ccse_dmem_model_i.mem[8'h11]);
    reg_read(2'h1, rd); chk("status", 8'h05, rd);
    $display("test complement done");

    // Ops less, equal, greater against f below, equal, above W; skip on the diagonal
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        fv = 8'h7f + 8'(j);
        skip = (i == j);
        reg_write(2'h0, 8'h80);
        reg_write(2'h1, 8'h03);
        ccse_dmem_model_i.poke(8'h20, fv);
        ccse_dmem_model_i.poke(8'h40, 8'h00);
        d0 = ccse_dmem_model_i.discards;
        run({8'h30 + 8'(i), 8'h20}, 16'h1340);
        chk("mem40", skip ? 8'h00 : 8'hff, ccse_dmem_model_i.mem[8'h40]);
        chk("discards", {7'h00, skip}, 8'(ccse_dmem_model_i.discards - d0));
        chk("mem20", fv, ccse_dmem_model_i.mem[8'h20]);
        reg_read(2'h0, rd); chk("w", 8'h80, rd);
        reg_read(2'h1, rd); chk("status", 8'h03, rd);
      end
    end
    $display("test compare done");

    reg_write(2'h0, 8'h23);
    reg_write(2'h1, 8'h02);
    run(16'h2e30, 16'h0000);
    chk("mem30", 8'h29, ccse_dmem_model_i.mem[8'h30]);
    reg_read(2'h0, rd); chk("w", 8'h29, rd);
    reg_read(2'h1, rd); chk("status", 8'h02, rd);
    reg_write(2'h0, 8'h9a);
    reg_write(2'h1, 8'h00);
    ccse_dmem_model_i.poke(8'h31, 8'h55);
    run(16'h2f31, 16'h0000);
    chk("mem31", 8'h00, ccse_dmem_model_i.mem[8'h31]);
    reg_read(2'h0, rd); chk("w", 8'h9a, rd);
    reg_read(2'h1, rd); chk("status", 8'h01, rd);
    $display("test decimal adjust done");
    finish_test;
  end
endmodule
